// file: rtl/tlb_ctrl_defines.svh
// constants for the translation-buffer control register group
// assumes coprocessor 0 decode by register number and select
//
// How it works
// [R1] set ignore_bit_mask bits drop their address bits from the compare
// [R2] page sizes 4 KB to 16 MB: mask grows two bits at a time from 13
// [R3] software loads only the listed mask patterns; others are undefined
// [R4] reserved bits read zero and software writes them as zero
// [R5] random writes never target entries below locked_entry_boundary
// [R6] indexed writes may overwrite any entry, locked ones included
// [R7] reset exception clears locked_entry_boundary to zero
// [R8] boundary writes reload the replacement pointer to the top entry
// [R9] software never writes a boundary at or above the entry count
// [R10] address-error and translation faults load faulting_virtual_address
// [R11] cache and bus errors leave faulting_virtual_address unchanged
// [R12] interval_counter steps once every two clocks, free of the pipeline
// [R13] software may write any counter value; counting resumes from it
// [R14] in debug mode the counter runs only with count_in_debug_enable
// [R15] translation faults put address bits 31:13 in virtual_page_pair_number
// [R16] after an address error the page pair number is left unspecified
// [R17] address_space_id is compared against each non-global entry's identifier on lookup
// [R18] an entry read loads its page pair number and identifier into the key
// [R19] software sets up the match key before a translation-buffer write
// [R20] writes take mask from page_size_mask; reads return it there
// [R21] with fixed_mapping_unit the mask, boundary and key read zero
`ifndef TLB_CTRL_DEFINES_SVH
`define TLB_CTRL_DEFINES_SVH

// ----------------------------------------------------------------
// register numbers, all at select 0
// ----------------------------------------------------------------
`define REG_PAGE_SIZE_MASK 5'h05
`define REG_LOCKED_BOUNDARY 5'h06
`define REG_FAULT_VADDR 5'h08
`define REG_INTERVAL_COUNTER 5'h09
`define REG_MATCH_KEY 5'h0a
`define REG_SELECT 3'h0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define MASK_MSB 24
`define MASK_LSB 13
`define VIRTUAL_PAGE_PAIR_NUMBER_MSB 31
`define VIRTUAL_PAGE_PAIR_NUMBER_LSB 13
`define ADDRESS_SPACE_ID_MSB 7
`define BOUND_MSB 3

// ----------------------------------------------------------------
// sizes, reset values and timing
// ----------------------------------------------------------------
`define ENTRY_COUNT 16
`define ENTRY_TOP 4'hf
`define BOUND_RESET 4'h0
`define MASK_RESET 12'h000
`define COUNT_RESET 32'h0000_0000
`define COUNT_PERIOD 2

`endif

// file: rtl/tlb_ctrl_pkg.sv
// types shared by the translation-buffer control register group
// assumes the constants header is compiled alongside
package tlb_ctrl_pkg;

  typedef struct packed {
    logic [4:0] regnum;
    logic [2:0] sel;
  } cp0_addr_t;

  typedef enum logic [2:0] {
    EXC_LOAD_ADDR = 3'h0,
    EXC_STORE_ADDR = 3'h1,
    EXC_REFILL = 3'h2,
    EXC_INVALID = 3'h3,
    EXC_MODIFIED = 3'h4,
    EXC_CACHE_ERR = 3'h5,
    EXC_BUS_ERR = 3'h6,
    EXC_OTHER = 3'h7
  } exc_kind_t;

  typedef struct packed {
    logic [18:0] virtual_page_pair_number;
    logic [7:0] address_space_id;
  } match_key_t;

  typedef struct packed {
    logic [18:0] virtual_page_pair_number;
    logic [11:0] mask;
    logic [7:0] address_space_id;
  } tlb_entry_t;

endpackage

// file: rtl/replacement_pointer.sv
// replacement pointer for random entry writes
// assumes the boundary input comes from a register on the same clock
`timescale 1ns/1ps
`include "tlb_ctrl_defines.svh"

module replacement_pointer (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // control
  input wire logic reload_i,
  input wire logic [3:0] bound_i,
  // pointer
  output logic [3:0] ptr_o
);

  logic [3:0] ptr_q;
  logic [3:0] ptr_d;

  // ----------------------------------------------------------------
  // count down, wrap to the top at the boundary
  // ----------------------------------------------------------------
  always_comb begin
    if (reload_i) begin
      ptr_d = `ENTRY_TOP; // R8
    end else if (ptr_q <= bound_i) begin
      ptr_d = `ENTRY_TOP; // R5
    end else begin
      ptr_d = ptr_q - 4'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr_q <= `ENTRY_TOP;
    end else begin
      ptr_q <= ptr_d;
    end
  end

  assign ptr_o = ptr_q;

endmodule

// file: rtl/tlb_ctrl_regs.sv
// translation-buffer control registers of coprocessor 0
// assumes all inputs are on mclk_i; the entry array sits outside
`timescale 1ns/1ps
`include "tlb_ctrl_defines.svh"

module tlb_ctrl_regs #(
  parameter bit FIXED_MAP_UNIT = 1'b0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic reset_exc_i,
  // coprocessor 0 access
  input wire logic cp0_wr_i,
  input wire logic cp0_rd_i,
  input wire tlb_ctrl_pkg::cp0_addr_t cp0_addr_i,
  input wire logic [31:0] cp0_wdata_i,
  output logic [31:0] cp0_rdata_o,
  // exceptions
  input wire logic exc_valid_i,
  input wire tlb_ctrl_pkg::exc_kind_t exc_kind_i,
  input wire logic [31:0] exc_vaddr_i,
  // debug
  input wire logic debug_mode_i,
  input wire logic count_in_debug_enable_i,
  // entry array read and write
  input wire logic tlb_read_i,
  input wire tlb_ctrl_pkg::tlb_entry_t tlb_read_entry_i,
  input wire logic indexed_entry_write_instr_i,
  input wire logic random_entry_write_instr_i,
  input wire logic [3:0] write_index_i,
  output logic tlb_wr_valid_o,
  output logic [3:0] tlb_wr_index_o,
  output tlb_ctrl_pkg::tlb_entry_t tlb_wr_entry_o,
  // lookup
  input wire logic [31:0] probe_vaddr_i,
  input wire tlb_ctrl_pkg::tlb_entry_t probe_entry_i,
  input wire logic probe_global_i,
  output logic probe_hit_o,
  output tlb_ctrl_pkg::match_key_t match_key_o,
  output logic [3:0] replace_index_o
);

  import tlb_ctrl_pkg::*;

  localparam bit TLB_ON = !FIXED_MAP_UNIT;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic sel_ok;
  logic wr_mask;
  logic wr_bound;
  logic wr_count;
  logic wr_key;
  logic tlb_exc;
  logic addr_exc;

  assign sel_ok = (cp0_addr_i.sel == `REG_SELECT);
  // fixed mapping turns the translation registers into reserved ones
  assign wr_mask = cp0_wr_i && sel_ok && TLB_ON &&
                   (cp0_addr_i.regnum == `REG_PAGE_SIZE_MASK); // R21
  assign wr_bound = cp0_wr_i && sel_ok && TLB_ON &&
                    (cp0_addr_i.regnum == `REG_LOCKED_BOUNDARY); // R21
  assign wr_key = cp0_wr_i && sel_ok && TLB_ON &&
                  (cp0_addr_i.regnum == `REG_MATCH_KEY); // R21
  assign wr_count = cp0_wr_i && sel_ok &&
                    (cp0_addr_i.regnum == `REG_INTERVAL_COUNTER);
  assign tlb_exc = exc_valid_i && (exc_kind_i == EXC_REFILL ||
                   exc_kind_i == EXC_INVALID || exc_kind_i == EXC_MODIFIED);
  assign addr_exc = exc_valid_i && (exc_kind_i == EXC_LOAD_ADDR ||
                    exc_kind_i == EXC_STORE_ADDR);

  // ----------------------------------------------------------------
  // page size mask and locked boundary
  // ----------------------------------------------------------------
  logic [11:0] mask_q;
  logic [11:0] mask_d;
  logic [3:0] bound_q;
  logic [3:0] bound_d;

  always_comb begin
    mask_d = mask_q;
    bound_d = bound_q;
    // only the listed patterns are meaningful; the rest is stored as is
    if (wr_mask) begin
      mask_d = cp0_wdata_i[`MASK_MSB:`MASK_LSB]; // R2 R3
    end
    if (tlb_read_i && TLB_ON) begin
      mask_d = tlb_read_entry_i.mask; // R20
    end
    if (wr_bound) begin
      bound_d = cp0_wdata_i[`BOUND_MSB:0]; // R9
    end
    if (reset_exc_i) begin
      bound_d = `BOUND_RESET; // R7
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mask_q <= `MASK_RESET;
      bound_q <= `BOUND_RESET;
    end else begin
      mask_q <= mask_d;
      bound_q <= bound_d;
    end
  end

  replacement_pointer u_replace (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .reload_i(wr_bound || reset_exc_i), // R8
    .bound_i(bound_q),
    .ptr_o(replace_index_o)
  );

  // ----------------------------------------------------------------
  // faulting address and match key
  // ----------------------------------------------------------------
  logic [31:0] fva_q;
  logic [31:0] fva_d;
  match_key_t key_q;
  match_key_t key_d;

  always_comb begin
    fva_d = fva_q;
    key_d = key_q;
    // cache and bus errors fall through and keep the old address
    if (tlb_exc || addr_exc) begin
      fva_d = exc_vaddr_i; // R10 R11
    end
    if (wr_key) begin
      key_d.virtual_page_pair_number = cp0_wdata_i[`VIRTUAL_PAGE_PAIR_NUMBER_MSB:`VIRTUAL_PAGE_PAIR_NUMBER_LSB]; // R19
      key_d.address_space_id = cp0_wdata_i[`ADDRESS_SPACE_ID_MSB:0];
    end
    // hardware updates win over a software write in the same cycle;
    // an address error simply leaves the page pair number alone
    if (tlb_read_i && TLB_ON) begin
      key_d.virtual_page_pair_number = tlb_read_entry_i.virtual_page_pair_number; // R18
      key_d.address_space_id = tlb_read_entry_i.address_space_id; // R18
    end
    if (tlb_exc && TLB_ON) begin
      key_d.virtual_page_pair_number = exc_vaddr_i[`VIRTUAL_PAGE_PAIR_NUMBER_MSB:`VIRTUAL_PAGE_PAIR_NUMBER_LSB]; // R15 R16
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fva_q <= 32'h0000_0000;
      key_q <= '0;
    end else begin
      fva_q <= fva_d;
      key_q <= key_d;
    end
  end

  assign match_key_o = key_q;

  // ----------------------------------------------------------------
  // interval counter
  // ----------------------------------------------------------------
  logic phase_q;
  logic phase_d;
  logic [31:0] count_q;
  logic [31:0] count_d;
  logic count_run;

  assign count_run = !debug_mode_i || count_in_debug_enable_i; // R14

  always_comb begin
    phase_d = !phase_q;
    count_d = count_q;
    if (wr_count) begin
      count_d = cp0_wdata_i; // R13
      phase_d = 1'b0;
    end else if (phase_q && count_run) begin
      count_d = count_q + 32'h0000_0001; // R12
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= 1'b0;
      count_q <= `COUNT_RESET;
    end else begin
      phase_q <= phase_d;
      count_q <= count_d;
    end
  end

  // ----------------------------------------------------------------
  // entry write request and lookup compare
  // ----------------------------------------------------------------
  logic wr_valid_q;
  logic wr_valid_d;
  logic [3:0] wr_index_q;
  logic [3:0] wr_index_d;
  tlb_entry_t wr_entry_q;
  tlb_entry_t wr_entry_d;
  logic hit_q;
  logic hit_d;
  logic [11:0] bit_ok;

  always_comb begin
    wr_valid_d = TLB_ON &&
                 (indexed_entry_write_instr_i || random_entry_write_instr_i);
    wr_index_d = wr_index_q;
    wr_entry_d = wr_entry_q;
    if (wr_valid_d) begin
      wr_entry_d = '{virtual_page_pair_number: key_q.virtual_page_pair_number, mask: mask_q,
                     address_space_id: key_q.address_space_id}; // R20
      // indexed writes reach any entry, locked ones too
      wr_index_d = indexed_entry_write_instr_i ?
                   write_index_i : replace_index_o; // R5 R6
    end
  end

  // masked bits of the page pair number never take part in the compare
  for (genvar i = 0; i < 12; i++) begin : g_mask
    assign bit_ok[i] = probe_entry_i.mask[i] ||
      (probe_vaddr_i[`VIRTUAL_PAGE_PAIR_NUMBER_LSB + i] == probe_entry_i.virtual_page_pair_number[i]); // R1
  end

  always_comb begin
    hit_d = TLB_ON && (&bit_ok) &&
            (probe_vaddr_i[`VIRTUAL_PAGE_PAIR_NUMBER_MSB:`MASK_MSB + 1] ==
             probe_entry_i.virtual_page_pair_number[18:12]) &&
            (probe_global_i || probe_entry_i.address_space_id == key_q.address_space_id); // R17
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_valid_q <= 1'b0;
      wr_index_q <= 4'h0;
      wr_entry_q <= '0;
      hit_q <= 1'b0;
    end else begin
      wr_valid_q <= wr_valid_d;
      wr_index_q <= wr_index_d;
      wr_entry_q <= wr_entry_d;
      hit_q <= hit_d;
    end
  end

  assign tlb_wr_valid_o = wr_valid_q;
  assign tlb_wr_index_o = wr_index_q;
  assign tlb_wr_entry_o = wr_entry_q;
  assign probe_hit_o = hit_q;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = rdata_q;
    if (cp0_rd_i) begin
      rdata_d = 32'h0000_0000;
      // reserved bits and unmapped numbers answer zero
      if (sel_ok) begin
        unique case (cp0_addr_i.regnum)
          `REG_PAGE_SIZE_MASK: begin
            if (TLB_ON) begin
              rdata_d[`MASK_MSB:`MASK_LSB] = mask_q; // R4 R21
            end
          end
          `REG_LOCKED_BOUNDARY: begin
            if (TLB_ON) begin
              rdata_d[`BOUND_MSB:0] = bound_q; // R4 R21
            end
          end
          `REG_FAULT_VADDR: begin
            rdata_d = fva_q;
          end
          `REG_INTERVAL_COUNTER: begin
            rdata_d = count_q;
          end
          `REG_MATCH_KEY: begin
            if (TLB_ON) begin
              rdata_d = {key_q.virtual_page_pair_number, 5'h00, key_q.address_space_id}; // R4 R21
            end
          end
          default: begin
            rdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign cp0_rdata_o = rdata_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  property p_bound_clear;
    reset_exc_i |=> bound_q == 4'h0 && replace_index_o == 4'hf;
  endproperty
  a_bound_clear: assert property (p_bound_clear) // R7
    else $error("boundary not cleared by reset exception");

  property p_floor;
    replace_index_o >= bound_q;
  endproperty
  a_floor: assert property (p_floor) // R5
    else $error("replacement pointer below boundary");

  property p_reload;
    wr_bound && !reset_exc_i |=> replace_index_o == 4'hf;
  endproperty
  a_reload: assert property (p_reload) // R8
    else $error("pointer not reloaded on boundary write");

  property p_count_step;
    !wr_count && count_run ##1 !wr_count && count_run |=>
      count_q == $past(count_q, 2) + 32'h0000_0001;
  endproperty
  a_count_step: assert property (p_count_step) // R12
    else $error("counter not one step per two clocks");

  property p_count_write;
    wr_count |=> count_q == $past(cp0_wdata_i);
  endproperty
  a_count_write: assert property (p_count_write) // R13
    else $error("counter write lost");

  property p_count_debug;
    debug_mode_i && !count_in_debug_enable_i && !wr_count |=>
      $stable(count_q);
  endproperty
  a_count_debug: assert property (p_count_debug) // R14
    else $error("counter moved in debug mode");

  property p_fva;
    tlb_exc || addr_exc |=> fva_q == $past(exc_vaddr_i);
  endproperty
  a_fva: assert property (p_fva) // R10
    else $error("faulting address not captured");

  property p_fva_keep;
    !(tlb_exc || addr_exc) |=> $stable(fva_q);
  endproperty
  a_fva_keep: assert property (p_fva_keep) // R11
    else $error("faulting address changed without cause");

  property p_virtual_page_pair_number;
    tlb_exc && TLB_ON |=> key_q.virtual_page_pair_number == $past(exc_vaddr_i[31:13]);
  endproperty
  a_virtual_page_pair_number: assert property (p_virtual_page_pair_number) // R15
    else $error("page pair number not loaded on exception");

  property p_read_load;
    tlb_read_i && !tlb_exc && TLB_ON |=>
      key_q.address_space_id == $past(tlb_read_entry_i.address_space_id) &&
      mask_q == $past(tlb_read_entry_i.mask);
  endproperty
  a_read_load: assert property (p_read_load) // R18
    else $error("entry read not loaded");

  property p_idx_write;
    indexed_entry_write_instr_i && TLB_ON |=>
      tlb_wr_valid_o && tlb_wr_index_o == $past(write_index_i);
  endproperty
  a_idx_write: assert property (p_idx_write) // R6
    else $error("indexed write went to wrong entry");

  logic wr_mask_rd;
  assign wr_mask_rd = sel_ok && cp0_addr_i.regnum == `REG_PAGE_SIZE_MASK;

  property p_reserved;
    cp0_rd_i |=> !$past(wr_mask_rd) ||
      {cp0_rdata_o[31:25], cp0_rdata_o[12:0]} == 20'h0_0000;
  endproperty

  a_reserved: assert property (p_reserved) // R4
    else $error("reserved mask bits not zero");

  c_random_write: cover property (random_entry_write_instr_i &&
                                  bound_q != 4'h0);
  c_count_write: cover property (wr_count ##2 !wr_count);
  c_tlb_exc: cover property (tlb_exc ##[1:2] cp0_rd_i);
  c_probe_hit: cover property (hit_q && key_q.address_space_id != 8'h00);

endmodule

// file: dv/tlb_control_register_group_tb.sv
// self-checking bench for the translation-buffer control registers
// assumes the design's package and constants header are compiled first
`timescale 1ns/1ps
`include "tlb_ctrl_defines.svh"

module tlb_control_register_group_tb;
  import tlb_ctrl_pkg::*;

  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic reset_exc_i = 1'b0;
  logic cp0_wr_i = 1'b0;
  logic cp0_rd_i = 1'b0;
  cp0_addr_t cp0_addr_i = '0;
  logic [31:0] cp0_wdata_i = '0;
  logic [31:0] cp0_rdata_o;
  logic exc_valid_i = 1'b0;
  exc_kind_t exc_kind_i = EXC_OTHER;
  logic [31:0] exc_vaddr_i = '0;
  logic debug_mode_i = 1'b0;
  logic count_in_debug_enable_i = 1'b0;
  logic tlb_read_i = 1'b0;
  tlb_entry_t tlb_read_entry_i = '0;
  logic indexed_entry_write_instr_i = 1'b0;
  logic random_entry_write_instr_i = 1'b0;
  logic [3:0] write_index_i = '0;
  logic tlb_wr_valid_o;
  logic [3:0] tlb_wr_index_o;
  tlb_entry_t tlb_wr_entry_o;
  logic [31:0] probe_vaddr_i = '0;
  tlb_entry_t probe_entry_i = '0;
  logic probe_global_i = 1'b0;
  logic probe_hit_o;
  match_key_t match_key_o;
  logic [3:0] replace_index_o;
  logic [31:0] fm_rdata;
  logic fm_wr_valid;
  logic fm_hit;
  int error_cnt = 0;
  int n_tests = 0;

  always #12.5 mclk_i = ~mclk_i;

  tlb_ctrl_regs tlb_ctrl_regs_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reset_exc_i(reset_exc_i),
    .cp0_wr_i(cp0_wr_i), .cp0_rd_i(cp0_rd_i), .cp0_addr_i(cp0_addr_i),
    .cp0_wdata_i(cp0_wdata_i), .cp0_rdata_o(cp0_rdata_o),
    .exc_valid_i(exc_valid_i), .exc_kind_i(exc_kind_i),
    .exc_vaddr_i(exc_vaddr_i), .debug_mode_i(debug_mode_i),
    .count_in_debug_enable_i(count_in_debug_enable_i),
    .tlb_read_i(tlb_read_i), .tlb_read_entry_i(tlb_read_entry_i),
    .indexed_entry_write_instr_i(indexed_entry_write_instr_i),
    .random_entry_write_instr_i(random_entry_write_instr_i),
    .write_index_i(write_index_i), .tlb_wr_valid_o(tlb_wr_valid_o),
    .tlb_wr_index_o(tlb_wr_index_o), .tlb_wr_entry_o(tlb_wr_entry_o),
    .probe_vaddr_i(probe_vaddr_i), .probe_entry_i(probe_entry_i),
    .probe_global_i(probe_global_i), .probe_hit_o(probe_hit_o),
    .match_key_o(match_key_o), .replace_index_o(replace_index_o)
  );

  // fixed mapping build: the translation registers are reserved
  tlb_ctrl_regs #(
    .FIXED_MAP_UNIT(1'b1)
  ) tlb_ctrl_regs_fm_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .reset_exc_i(reset_exc_i),
    .cp0_wr_i(cp0_wr_i), .cp0_rd_i(cp0_rd_i), .cp0_addr_i(cp0_addr_i),
    .cp0_wdata_i(cp0_wdata_i), .cp0_rdata_o(fm_rdata),
    .exc_valid_i(exc_valid_i), .exc_kind_i(exc_kind_i),
    .exc_vaddr_i(exc_vaddr_i), .debug_mode_i(debug_mode_i),
    .count_in_debug_enable_i(count_in_debug_enable_i),
    .tlb_read_i(tlb_read_i), .tlb_read_entry_i(tlb_read_entry_i),
    .indexed_entry_write_instr_i(indexed_entry_write_instr_i),
    .random_entry_write_instr_i(random_entry_write_instr_i),
    .write_index_i(write_index_i), .tlb_wr_valid_o(fm_wr_valid),
    .tlb_wr_index_o(), .tlb_wr_entry_o(),
    .probe_vaddr_i(probe_vaddr_i), .probe_entry_i(probe_entry_i),
    .probe_global_i(probe_global_i), .probe_hit_o(fm_hit),
    .match_key_o(), .replace_index_o()
  );

  // ----------------------------------------------------------------
  // access tasks, all entered just after a falling edge
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // each access lets one edge pass first, so back-to-back calls never
  // raise a strobe in the same step that dropped it
  task automatic wr(input logic [4:0] r, input logic [31:0] d);
    @(negedge mclk_i);
    cp0_addr_i = '{regnum: r, sel: `REG_SELECT};
    cp0_wdata_i = d;
    cp0_wr_i = 1'b1;
    @(negedge mclk_i);
    cp0_wr_i = 1'b0;
  endtask

  // read data is registered at the read edge, so it is settled here
  task automatic rchk(input string nm, input logic [4:0] r,
                      input logic [2:0] s, input logic [31:0] e);
    @(negedge mclk_i);
    cp0_addr_i = '{regnum: r, sel: s};
    cp0_rd_i = 1'b1;
    @(negedge mclk_i);
    cp0_rd_i = 1'b0;
    chk(nm, e, cp0_rdata_o);
  endtask

  task automatic exc(input int k, input logic [31:0] va);
    exc_kind_i = exc_kind_t'(k);
    exc_vaddr_i = va;
    exc_valid_i = 1'b1;
    @(negedge mclk_i);
    exc_valid_i = 1'b0;
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // watchdog: the whole sequence needs well under a thousand cycles
  // ----------------------------------------------------------------
  initial begin
    repeat (5000) @(posedge mclk_i);
    error_cnt++;
    close_out();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] m;
    logic [31:0] va;
    logic [31:0] last;
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    // the pointer runs from the first edge on, so look before it
    chk("pointer reset", 32'hf, 32'(replace_index_o));
    rchk("boundary reset", `REG_LOCKED_BOUNDARY, 3'h0, 32'h0);
    rchk("unmapped reg", 5'h07, 3'h0, 32'h0);
    rchk("bad select", `REG_LOCKED_BOUNDARY, 3'h1, 32'h0);
    $display("test reset done");

    wr(`REG_PAGE_SIZE_MASK, 32'hffff_ffff);
    rchk("mask reserved", `REG_PAGE_SIZE_MASK, 3'h0, 32'h01ff_e000);
    chk("fm mask", 32'h0, fm_rdata);
    wr(`REG_LOCKED_BOUNDARY, 32'hffff_fff3);
    rchk("bound reserved", `REG_LOCKED_BOUNDARY, 3'h0, 32'h3);
    chk("fm bound", 32'h0, fm_rdata);
    wr(`REG_MATCH_KEY, 32'hffff_ffff);
    rchk("key reserved", `REG_MATCH_KEY, 3'h0, 32'hffff_e0ff);
    chk("fm key", 32'h0, fm_rdata);
    wr(`REG_MATCH_KEY, 32'h1234_605a);
    $display("test reserved bits done");

    // every page size goes out with an indexed write of the entry
    for (int i = 0; i < 7; i++) begin
      m = 12'((1 << (2 * i)) - 1);
      wr(`REG_PAGE_SIZE_MASK, {7'h0, m, 13'h0});
      rchk("mask", `REG_PAGE_SIZE_MASK, 3'h0, {7'h0, m, 13'h0});
      write_index_i = 4'(i);
      indexed_entry_write_instr_i = 1'b1;
      @(negedge mclk_i);
      indexed_entry_write_instr_i = 1'b0;
      chk("wr valid", 32'h1, 32'(tlb_wr_valid_o));
      chk("fm wr valid", 32'h0, 32'(fm_wr_valid));
      chk("wr index", 32'(i), 32'(tlb_wr_index_o));
      chk("wr virtual_page_pair_number", 32'h0000_91a3, 32'(tlb_wr_entry_o.virtual_page_pair_number));
      chk("wr mask address_space_id", {12'h000, m, 8'h5a},
          {12'h000, tlb_wr_entry_o.mask, tlb_wr_entry_o.address_space_id});
    end
    $display("test page sizes done");

    // held request gives back-to-back random writes
    for (int b = 1; b < 16; b += 7) begin
      wr(`REG_LOCKED_BOUNDARY, 32'(b));
      chk("reload", 32'hf, 32'(replace_index_o));
      random_entry_write_instr_i = 1'b1;
      repeat (20) begin
        @(negedge mclk_i);
        chk("rand valid", 32'h1, 32'(tlb_wr_valid_o));
        chk("rand floor", 32'h1, 32'(tlb_wr_index_o >= 4'(b)));
      end
      random_entry_write_instr_i = 1'b0;
    end
    write_index_i = 4'h0;
    indexed_entry_write_instr_i = 1'b1;
    @(negedge mclk_i);
    indexed_entry_write_instr_i = 1'b0;
    chk("locked overwrite", 32'h0, 32'(tlb_wr_index_o));
    reset_exc_i = 1'b1;
    @(negedge mclk_i);
    reset_exc_i = 1'b0;
    chk("exc pointer", 32'hf, 32'(replace_index_o));
    chk("wr valid end", 32'h0, 32'(tlb_wr_valid_o));
    rchk("exc boundary", `REG_LOCKED_BOUNDARY, 3'h0, 32'h0);
    $display("test replacement done");

    last = 32'h0;
    for (int k = 0; k < 7; k++) begin
      va = {4'(k + 9), 28'h5a6_b7c8};
      exc(k, va);
      if (k < 5) begin
        last = va;
      end
      if (k >= 2 && k < 5) begin
        chk("key virtual_page_pair_number", 32'(va[31:13]), 32'(match_key_o.virtual_page_pair_number));
      end
      rchk("fault addr", `REG_FAULT_VADDR, 3'h0, last);
    end
    wr(`REG_FAULT_VADDR, 32'h0);
    rchk("fault ro", `REG_FAULT_VADDR, 3'h0, last);
    $display("test fault capture done");

    tlb_read_entry_i = '{virtual_page_pair_number: 19'h55555, mask: 12'h03f, address_space_id: 8'hc3};
    tlb_read_i = 1'b1;
    @(negedge mclk_i);
    tlb_read_i = 1'b0;
    rchk("read key", `REG_MATCH_KEY, 3'h0, 32'haaaa_a0c3);
    rchk("read mask", `REG_PAGE_SIZE_MASK, 3'h0, 32'h0007_e000);
    $display("test entry read done");

    // entry mask covers virtual_page_pair_number[3:0]; only an unmasked bit or address_space_id misses
    wr(`REG_MATCH_KEY, 32'h1234_605a);
    for (int i = 0; i < 4; i++) begin
      probe_vaddr_i = {19'h091a3 ^ ((i == 0) ? 19'h3 :
                       (i == 1) ? 19'h10 : 19'h0), 13'h0abc};
      probe_entry_i = '{virtual_page_pair_number: 19'h091a3, mask: 12'h00f,
                        address_space_id: (i >= 2) ? 8'h5b : 8'h5a};
      probe_global_i = (i == 3);
      @(negedge mclk_i);
      chk("probe hit", 32'(i != 1 && i != 2), 32'(probe_hit_o));
      chk("fm hit", 32'h0, 32'(fm_hit));
    end
    $display("test lookup done");

    for (int d = 0; d < 3; d++) begin
      debug_mode_i = (d > 0);
      count_in_debug_enable_i = (d == 2);
      wr(`REG_INTERVAL_COUNTER, 32'hffff_fffe);
      // reads sit two clocks apart, so a running counter moves one step
      for (int i = 0; i < 5; i++) begin
        rchk("counter", `REG_INTERVAL_COUNTER, 3'h0,
             32'hffff_fffe + ((d == 1) ? 32'h0 : 32'(i)));
      end
    end
    $display("test counter done");
    close_out();
  end
endmodule
